/* sbt_defines.svh */
`ifndef SBT_DEFINES_SVH
`define SBT_DEFINES_SVH

// instruction register
`define SBT_IR_W 3
`define SBT_IR_CAPTURE 3'h1
`define SBT_IR_EXTEST 3'h0
`define SBT_IR_IDCODE 3'h1
`define SBT_IR_SAMPLE_Z 3'h2
`define SBT_IR_SAMPLE 3'h4
`define SBT_IR_BYPASS 3'h7

// scan register lengths
`define SBT_ID_W 32
`define SBT_BSR_LEN 72

// value is arbitrary, bit 0 set as every id code needs
`define SBT_IDCODE_DEFAULT 32'h0A5A_5001

// reset values
`define SBT_PULL_LEVEL 1'b1
`define SBT_TCK_IDLE 1'b0
`define SBT_BYP_RESET 1'b0

// link timing
`define SBT_TCK_MIN_NS 50
`define SBT_CORE_NS 10
`define SBT_SYNC_STAGES 2

// snapshot buffer
`define SBT_BUF_DEPTH 2

`endif

/* sbt_pkg.sv */
`include "sbt_defines.svh"
package sbt_pkg;

  typedef enum logic [3:0] {
    ST_TLR = 4'h0,
    ST_RTI = 4'h1,
    ST_SEL_DR = 4'h3,
    ST_CAP_DR = 4'h2,
    ST_SH_DR = 4'h6,
    ST_EX1_DR = 4'h7,
    ST_PA_DR = 4'h5,
    ST_EX2_DR = 4'h4,
    ST_UPD_DR = 4'hC,
    ST_SEL_IR = 4'hD,
    ST_CAP_IR = 4'hF,
    ST_SH_IR = 4'hE,
    ST_EX1_IR = 4'hA,
    ST_PA_IR = 4'hB,
    ST_EX2_IR = 4'h9,
    ST_UPD_IR = 4'h8
  } sbt_tap_state_t;

  typedef enum logic [1:0] {
    SEL_BYP = 2'h0,
    SEL_ID = 2'h1,
    SEL_BSR = 2'h2
  } sbt_dr_sel_t;

  typedef struct packed {
    logic [`SBT_BSR_LEN-1:0] cells;
  } sbt_ring_t;

  typedef struct packed {
    logic tck_m;
    logic tck_s;
    logic tck_p;
    logic tms_m;
    logic tms_s;
    logic tdi_m;
    logic tdi_s;
    sbt_tap_state_t st;
    logic [`SBT_IR_W-1:0] ir_sh;
    logic [`SBT_IR_W-1:0] ir;
    logic byp;
    logic [`SBT_ID_W-1:0] idr;
    sbt_ring_t bsr;
    logic tdo;
    logic tdo_oe;
    logic hiz;
  } sbt_state_t;

endpackage

/* sbt_buf2.sv */
`timescale 1ns/1ps
module sbt_buf2 #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
  } buf_state_t;

  buf_state_t q;
  buf_state_t d;
  logic push;
  logic pop;

  assign in_ready = (q.cnt != CW'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp = (q.wp == PW'(DEPTH - 1)) ? '0 : q.wp + PW'(1);
    end
    if (pop) begin
      d.rp = (q.rp == PW'(DEPTH - 1)) ? '0 : q.rp + PW'(1);
    end
    d.cnt = q.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule

/* sbt_tap.sv */
`timescale 1ns/1ps
`include "sbt_defines.svh"

// Notes on behaviour
// - inputs taken on tck rise, tdo on fall
// - mode select steers controller, reads high unconnected
// - serial data in reads high unconnected
// - data in enters selected register MSB
// - data out shows selected register LSB
// - data out driven only in shift states
// - five mode-select highs reset controller safely
// - power-up reset leaves data out floating
// - exactly one register, chosen by instruction
// - instruction register three bits, serial load
// - reset state loads identification instruction
// - capture-ir forces two LSBs to 01
// - bypass bit, cleared when bypass selected
// - boundary register, MSB at data in
// - capture-dr snapshots ring, shift-dr shifts it
// - extest, sample, sample-z select boundary register
// - idcode capture loads fixed 32-bit code
// - all-zero extest samples and floats outputs
// - sample-z shifts ring and floats outputs
// - new instruction acts only after update-ir
module sbt_tap #(
  parameter logic [`SBT_ID_W-1:0] ID_CODE = `SBT_IDCODE_DEFAULT
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  input wire sbt_pkg::sbt_ring_t ring_data,
  input wire logic ring_valid,
  output logic ring_ready,
  output logic outputs_hiz,
  output logic [`SBT_IR_W-1:0] active_instr
);

  sbt_pkg::sbt_state_t q;
  sbt_pkg::sbt_state_t d;

  logic tck_rise;
  logic tck_fall;
  logic [`SBT_BSR_LEN-1:0] snap_data;
  logic snap_valid;
  logic snap_take;
  sbt_pkg::sbt_dr_sel_t dr_sel;

  // ring snapshots queue here; a capture takes the oldest one
  sbt_buf2 #(
    .W(`SBT_BSR_LEN),
    .DEPTH(`SBT_BUF_DEPTH)
  ) u_snap (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .in_data(ring_data.cells),
    .in_valid(ring_valid),
    .in_ready(ring_ready),
    .out_data(snap_data),
    .out_valid(snap_valid),
    .out_ready(snap_take)
  );

  function automatic sbt_pkg::sbt_dr_sel_t select_dr(
    input logic [`SBT_IR_W-1:0] instr
  );
    sbt_pkg::sbt_dr_sel_t sel;
    sel = sbt_pkg::SEL_BYP;
    case (instr)
      `SBT_IR_IDCODE: begin
        sel = sbt_pkg::SEL_ID;
      end
      `SBT_IR_EXTEST,
      `SBT_IR_SAMPLE,
      `SBT_IR_SAMPLE_Z: begin
        sel = sbt_pkg::SEL_BSR;
      end
      default: begin
        sel = sbt_pkg::SEL_BYP;
      end
    endcase
    return sel;
  endfunction

  function automatic logic floats_outputs(
    input logic [`SBT_IR_W-1:0] instr
  );
    logic f;
    f = 1'b0;
    if (instr == `SBT_IR_EXTEST) begin
      f = 1'b1;
    end else if (instr == `SBT_IR_SAMPLE_Z) begin
      f = 1'b1;
    end
    return f;
  endfunction

  function automatic sbt_pkg::sbt_tap_state_t next_state(
    input sbt_pkg::sbt_tap_state_t st,
    input logic m
  );
    sbt_pkg::sbt_tap_state_t n;
    n = sbt_pkg::ST_TLR;
    case (st)
      sbt_pkg::ST_TLR: begin
        n = m ? sbt_pkg::ST_TLR : sbt_pkg::ST_RTI;
      end
      sbt_pkg::ST_RTI: begin
        n = m ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_RTI;
      end
      sbt_pkg::ST_SEL_DR: begin
        n = m ? sbt_pkg::ST_SEL_IR : sbt_pkg::ST_CAP_DR;
      end
      sbt_pkg::ST_CAP_DR: begin
        n = m ? sbt_pkg::ST_EX1_DR : sbt_pkg::ST_SH_DR;
      end
      sbt_pkg::ST_SH_DR: begin
        n = m ? sbt_pkg::ST_EX1_DR : sbt_pkg::ST_SH_DR;
      end
      sbt_pkg::ST_EX1_DR: begin
        n = m ? sbt_pkg::ST_UPD_DR : sbt_pkg::ST_PA_DR;
      end
      sbt_pkg::ST_PA_DR: begin
        n = m ? sbt_pkg::ST_EX2_DR : sbt_pkg::ST_PA_DR;
      end
      sbt_pkg::ST_EX2_DR: begin
        n = m ? sbt_pkg::ST_UPD_DR : sbt_pkg::ST_SH_DR;
      end
      sbt_pkg::ST_UPD_DR: begin
        n = m ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_RTI;
      end
      sbt_pkg::ST_SEL_IR: begin
        n = m ? sbt_pkg::ST_TLR : sbt_pkg::ST_CAP_IR;
      end
      sbt_pkg::ST_CAP_IR: begin
        n = m ? sbt_pkg::ST_EX1_IR : sbt_pkg::ST_SH_IR;
      end
      sbt_pkg::ST_SH_IR: begin
        n = m ? sbt_pkg::ST_EX1_IR : sbt_pkg::ST_SH_IR;
      end
      sbt_pkg::ST_EX1_IR: begin
        n = m ? sbt_pkg::ST_UPD_IR : sbt_pkg::ST_PA_IR;
      end
      sbt_pkg::ST_PA_IR: begin
        n = m ? sbt_pkg::ST_EX2_IR : sbt_pkg::ST_PA_IR;
      end
      sbt_pkg::ST_EX2_IR: begin
        n = m ? sbt_pkg::ST_UPD_IR : sbt_pkg::ST_SH_IR;
      end
      sbt_pkg::ST_UPD_IR: begin
        n = m ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_RTI;
      end
      default: begin
        n = sbt_pkg::ST_TLR;
      end
    endcase
    return n;
  endfunction

  // edges are found on the second stage against a third copy
  assign tck_rise = q.tck_s & ~q.tck_p;
  assign tck_fall = ~q.tck_s & q.tck_p;
  assign dr_sel = select_dr(q.ir);

  // a capture with no fresh snapshot leaves the boundary register as it was, shifted bits included
  assign snap_take = tck_rise && (q.st == sbt_pkg::ST_CAP_DR) &&
                     (dr_sel == sbt_pkg::SEL_BSR);

  always_comb begin
    d = q;

    // synchronisers; tms and tdi share the tck delay so stay aligned
    d.tck_m = tck;
    d.tck_s = q.tck_m;
    d.tck_p = q.tck_s;
    d.tms_m = tms;
    d.tms_s = q.tms_m;
    d.tdi_m = tdi;
    d.tdi_s = q.tdi_m;

    if (tck_rise) begin
      d.st = next_state(q.st, q.tms_s);
      case (q.st)
        sbt_pkg::ST_CAP_IR: begin
          d.ir_sh = `SBT_IR_CAPTURE;
        end
        sbt_pkg::ST_SH_IR: begin
          d.ir_sh = {q.tdi_s, q.ir_sh[`SBT_IR_W-1:1]};
        end
        sbt_pkg::ST_UPD_IR: begin
          d.ir = q.ir_sh;
        end
        sbt_pkg::ST_CAP_DR: begin
          case (dr_sel)
            sbt_pkg::SEL_ID: begin
              d.idr = ID_CODE;
            end
            sbt_pkg::SEL_BSR: begin
              if (snap_valid) begin
                d.bsr.cells = snap_data;
              end
            end
            default: begin
              d.byp = `SBT_BYP_RESET;
            end
          endcase
        end
        sbt_pkg::ST_SH_DR: begin
          case (dr_sel)
            sbt_pkg::SEL_ID: begin
              d.idr = {q.tdi_s, q.idr[`SBT_ID_W-1:1]};
            end
            sbt_pkg::SEL_BSR: begin
              d.bsr.cells = {q.tdi_s, q.bsr.cells[`SBT_BSR_LEN-1:1]};
            end
            default: begin
              d.byp = q.tdi_s;
            end
          endcase
        end
        default: begin
          d.ir_sh = q.ir_sh;
        end
      endcase
      if (d.st == sbt_pkg::ST_TLR) begin
        // held high tms reaches this state in at most five rises
        d.ir = `SBT_IR_IDCODE;
      end
    end

    if (tck_fall) begin
      if (q.st == sbt_pkg::ST_SH_IR) begin
        d.tdo = q.ir_sh[0];
        d.tdo_oe = 1'b1;
      end else if (q.st == sbt_pkg::ST_SH_DR) begin
        d.tdo_oe = 1'b1;
        case (dr_sel)
          sbt_pkg::SEL_ID: begin
            d.tdo = q.idr[0];
          end
          sbt_pkg::SEL_BSR: begin
            d.tdo = q.bsr.cells[0];
          end
          default: begin
            d.tdo = q.byp;
          end
        endcase
      end else begin
        d.tdo = 1'b0;
        d.tdo_oe = 1'b0;
      end
    end

    // memory outputs follow the instruction in force, not the shifted one
    d.hiz = floats_outputs(d.ir);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
      q.tck_m <= `SBT_TCK_IDLE;
      q.tck_s <= `SBT_TCK_IDLE;
      q.tck_p <= `SBT_TCK_IDLE;
      // undriven pads read high through the pull-ups
      q.tms_m <= `SBT_PULL_LEVEL;
      q.tms_s <= `SBT_PULL_LEVEL;
      q.tdi_m <= `SBT_PULL_LEVEL;
      q.tdi_s <= `SBT_PULL_LEVEL;
      q.st <= sbt_pkg::ST_TLR;
      q.ir <= `SBT_IR_IDCODE;
      q.ir_sh <= `SBT_IR_CAPTURE;
      q.tdo_oe <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign tdo = q.tdo;
  assign tdo_oe = q.tdo_oe;
  assign outputs_hiz = q.hiz;
  assign active_instr = q.ir;

endmodule

/* sbt_tap_asserts.sv */
`timescale 1ns/1ps
`include "sbt_defines.svh"
module sbt_tap_asserts (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire sbt_pkg::sbt_ring_t ring_data,
  input wire logic ring_valid,
  input wire logic ring_ready,
  input wire logic outputs_hiz,
  input wire logic [`SBT_IR_W-1:0] active_instr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_tdo_quiet;
    $stable(tdo) [*4];
  endsequence
  sequence s_tdo_hold;
    $stable(tdo) [*2];
  endsequence
  a_rst_state: assert property ($rose(arst_n) |->
    !tdo_oe && active_instr == `SBT_IR_IDCODE) else $error("bad reset");
  a_tdo_rise: assert property ($rose(tck) |-> ##2 s_tdo_quiet)
    else $error("tdo moved after rise");
  a_tdo_fall: assert property ($fell(tck) |-> s_tdo_hold)
    else $error("tdo moved too early");
  a_hiz_map: assert property ($stable(active_instr) [*2] |->
    outputs_hiz == (active_instr == `SBT_IR_EXTEST ||
    active_instr == `SBT_IR_SAMPLE_Z)) else $error("hiz mismatch");
  a_instr_edge: assert property ($changed(active_instr) |->
    $past(tck, 2)) else $error("instr changed off update");
  a_oe_edge: assert property ($changed(tdo_oe) |->
    !$past(tck, 2)) else $error("oe changed off fall");
  a_ready_pop: assert property ($rose(ring_ready) |->
    $past(tck, 2)) else $error("pop without capture");
  a_full_hold: assert property (!ring_ready && !tck |=>
    !ring_ready) else $error("full buffer drained");
endmodule
bind sbt_tap sbt_tap_asserts u_sbt_tap_asserts (
  .core_clk(core_clk), .arst_n(arst_n), .tck(tck), .tms(tms),
  .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .ring_data(ring_data),
  .ring_valid(ring_valid), .ring_ready(ring_ready),
  .outputs_hiz(outputs_hiz), .active_instr(active_instr));

/* sbt_ctl.sv */
`timescale 1ns/1ps
module sbt_ctl (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo_w
);
  // idle at pull-up level, tck parked low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // inputs move on the fall, tdo read mid high phase
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #40 tck = 1'b1;
    #20 o = tdo_w;
    #20 tck = 1'b0;
  endtask
  task automatic reset5;
    logic o;
    repeat (5) step(1'b1, 1'b1, o);
  endtask
endmodule

/* sbt_tap_tb_top.sv */
`timescale 1ns/1ps
`include "sbt_defines.svh"
module sbt_tap_tb_top;
  logic core_clk;
  logic arst_n;
  logic ring_valid;
  sbt_pkg::sbt_ring_t ring_data;
  wire tck, tms, tdi, tdo, tdo_oe, ring_ready, outputs_hiz;
  wire [2:0] active_instr;
  wire tdo_w = tdo_oe ? tdo : 1'bz;
  int n_fail = 0;
  int n_checks = 0;
  logic [71:0] got;
  sbt_tap u_sbt_tap (.core_clk(core_clk), .arst_n(arst_n), .tck(tck),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .ring_data(ring_data), .ring_valid(ring_valid),
    .ring_ready(ring_ready), .outputs_hiz(outputs_hiz),
    .active_instr(active_instr));
  sbt_ctl u_sbt_ctl (.tck(tck), .tms(tms), .tdi(tdi), .tdo_w(tdo_w));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic cmp(input logic [71:0] g, input logic [71:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // from idle: capture, shift n bits lsb first, update, back to idle
  task automatic scan(input bit ir, input int n, input logic [71:0] d);
    logic o;
    u_sbt_ctl.step(1'b1, 1'b1, o);
    if (ir)
      u_sbt_ctl.step(1'b1, 1'b1, o);
    u_sbt_ctl.step(1'b0, 1'b1, o);
    u_sbt_ctl.step(1'b0, 1'b1, o);
    got = '0;
    for (int i = 0; i < n; i++) begin
      u_sbt_ctl.step(i == n - 1, d[i], o);
      got[i] = o;
    end
    u_sbt_ctl.step(1'b1, 1'b1, o);
    u_sbt_ctl.step(1'b0, 1'b1, o);
  endtask
  task automatic set_ir(input logic [2:0] c);
    scan(1'b1, 3, {69'h0, c});
    cmp(got, 72'h1);
    #50;
    cmp(active_instr, c);
    cmp(outputs_hiz, c == 3'h0 || c == 3'h2);
    cmp(tdo_oe, 1'b0);
  endtask
  task automatic push(input sbt_pkg::sbt_ring_t w, input bit last);
    ring_data <= w;
    ring_valid <= 1'b1;
    @(negedge core_clk);
    for (int k = 0; k < 50 && ring_ready !== 1'b1; k++)
      @(negedge core_clk);
    @(posedge core_clk);
    if (last)
      ring_valid <= 1'b0;
  endtask
  task automatic t_reset;
    logic o;
    cmp(active_instr, `SBT_IR_IDCODE);
    cmp(tdo_oe, 1'b0);
    cmp(ring_ready, 1'b1);
    u_sbt_ctl.step(1'b0, 1'b1, o);
  endtask
  task automatic t_idcode;
    scan(1'b0, 64, 72'h1234_5678);
    cmp(got, {8'h0, 32'h1234_5678, `SBT_IDCODE_DEFAULT});
  endtask
  task automatic t_bypass;
    logic [11:0] cs;
    cs = {3'h6, 3'h5, 3'h3, 3'h7};
    for (int i = 0; i < 4; i++) begin
      set_ir(cs[3*i+:3]);
      scan(1'b0, 8, 72'hA5);
      cmp(got, 72'h4A);
    end
  endtask
  task automatic t_ring;
    logic [215:0] ws;
    ws = {72'hC6_5A5A_0F0F_33CC_9911, 72'h01_FEDC_BA98_7654_3210,
      72'h80_0123_4567_89AB_CDEF};
    @(posedge core_clk);
    push(ws[71:0], 1'b0);
    push(ws[143:72], 1'b1);
    @(negedge core_clk);
    cmp(ring_ready, 1'b0);
    set_ir(`SBT_IR_SAMPLE);
    scan(1'b0, 72, 72'h0);
    cmp(got, ws[71:0]);
    set_ir(`SBT_IR_EXTEST);
    scan(1'b0, 72, 72'h0);
    cmp(got, ws[143:72]);
    @(posedge core_clk);
    push(ws[215:144], 1'b1);
    set_ir(`SBT_IR_SAMPLE_Z);
    scan(1'b0, 72, 72'h0);
    cmp(got, ws[215:144]);
  endtask
  task automatic t_tms_reset;
    logic o;
    u_sbt_ctl.step(1'b1, 1'b1, o);
    u_sbt_ctl.step(1'b0, 1'b1, o);
    u_sbt_ctl.step(1'b0, 1'b1, o);
    #50;
    cmp(tdo_oe, 1'b1);
    u_sbt_ctl.reset5;
    #50;
    cmp(active_instr, `SBT_IR_IDCODE);
    cmp(outputs_hiz, 1'b0);
    cmp(tdo_oe, 1'b0);
  endtask
  initial begin
    arst_n = 1'b0;
    ring_valid = 1'b0;
    ring_data = '0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_reset;
    t_idcode;
    t_bypass;
    t_ring;
    t_tms_reset;
    give_verdict;
  end
  // a full run needs about 34 us
  initial begin
    #500us;
    n_fail++;
    give_verdict;
  end
endmodule
